/* File: gpw_pkg.sv */
// Shared constants and types for the three-port GPIO block with port A wake-up.
package gpw_pkg;

	// ==========================================================================
	// Widths
	// ==========================================================================
	localparam int REG_W = 8;
	localparam int ADDR_W = 8;
	localparam int PORT_CNT = 3;
	localparam int PA_WIDTH = 8;
	localparam int PB_WIDTH = 8;
	localparam int PC_WIDTH = 6;

	// ==========================================================================
	// Data memory locations of the port registers
	// ==========================================================================
	localparam logic [ADDR_W-1:0] ADDR_PA_DATA = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_PA_DIR = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_PA_PU = 8'h02;
	localparam logic [ADDR_W-1:0] ADDR_PA_WAKE = 8'h03;
	localparam logic [ADDR_W-1:0] ADDR_PB_DATA = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_PB_DIR = 8'h05;
	localparam logic [ADDR_W-1:0] ADDR_PB_PU = 8'h06;
	localparam logic [ADDR_W-1:0] ADDR_PC_DATA = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_PC_DIR = 8'h09;
	localparam logic [ADDR_W-1:0] ADDR_PC_PU = 8'h0a;

	// ==========================================================================
	// Reset values
	// ==========================================================================
	localparam logic [REG_W-1:0] DATA_RST = 8'hff;
	localparam logic [REG_W-1:0] DIR_RST = 8'hff;
	localparam logic [REG_W-1:0] PU_RST = 8'h00;
	localparam logic [REG_W-1:0] WAKE_RST = 8'h00;
	localparam logic [REG_W-1:0] ZERO = 8'h00;

	// ==========================================================================
	// Power modes
	// ==========================================================================
	typedef enum logic [1:0] {
		GPW_RUN,
		GPW_IDLE,
		GPW_SLEEP
	} gpw_mode_t;

endpackage

/* File: gpw_wake_if.sv */
// Interface carrying port A wake-up signals between the GPIO top and its detector.
`timescale 1ns/1ps
`default_nettype none
interface gpw_wake_if;
	logic [gpw_pkg::PA_WIDTH-1:0] pin;
	logic [gpw_pkg::PA_WIDTH-1:0] dir;
	logic [gpw_pkg::PA_WIDTH-1:0] wake_en;
	logic low_power;
	logic wake_req;

	modport top (output pin, output dir, output wake_en, output low_power, input wake_req);
	modport wake (input pin, input dir, input wake_en, input low_power, output wake_req);
endinterface
`default_nettype wire

/* File: gpw_wake.sv */
// Port A falling-edge wake-up detector.
`timescale 1ns/1ps
`default_nettype none
module gpw_wake (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	gpw_wake_if.wake wk
);

	logic [gpw_pkg::PA_WIDTH-1:0] sync1;
	logic [gpw_pkg::PA_WIDTH-1:0] sync2;
	logic [gpw_pkg::PA_WIDTH-1:0] prev;
	logic [gpw_pkg::PA_WIDTH-1:0] fall;

	// ==========================================================================
	// Synchroniser and edge history
	// ==========================================================================
	// Reset to high so a pin that idles high is not seen as falling at start.
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			sync1 <= '1;
			sync2 <= '1;
			prev <= '1;
		end else begin
			sync1 <= wk.pin;
			sync2 <= sync1;
			prev <= sync2;
		end
	end

	// ==========================================================================
	// Enabled falling edges, only on inputs and only in idle or sleep mode
	// ==========================================================================
	assign fall = prev & ~sync2 & wk.wake_en & wk.dir;

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			wk.wake_req <= 1'b0;
		end else begin
			wk.wake_req <= wk.low_power && (|fall);
		end
	end

endmodule
`default_nettype wire

/* File: gpw_top.sv */
// Three-port GPIO with data latches, direction, pull-high and port A wake-up.
`timescale 1ns/1ps
`default_nettype none
module gpw_top #(
	parameter int PA_W = gpw_pkg::PA_WIDTH,
	parameter int PB_W = gpw_pkg::PB_WIDTH,
	parameter int PC_W = gpw_pkg::PC_WIDTH
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [gpw_pkg::ADDR_W-1:0] mem_addr_i,
	input wire logic mem_wr_i,
	input wire logic mem_rd_i,
	input wire logic [gpw_pkg::REG_W-1:0] mem_wdata_i,
	output logic [gpw_pkg::REG_W-1:0] mem_rdata_o,
	output logic mem_hit_o,
	input wire logic halt_i,
	input wire logic halt_sleep_i,
	input wire logic other_wake_i,
	output logic [1:0] power_mode_o,
	output logic wake_req_o,
	input wire logic [PA_W-1:0] pa_pin_i,
	output logic [PA_W-1:0] pa_pin_o,
	output logic [PA_W-1:0] pa_pin_oe_n_o,
	output logic [PA_W-1:0] pa_pull_o,
	input wire logic [PB_W-1:0] pb_pin_i,
	output logic [PB_W-1:0] pb_pin_o,
	output logic [PB_W-1:0] pb_pin_oe_n_o,
	output logic [PB_W-1:0] pb_pull_o,
	input wire logic [PC_W-1:0] pc_pin_i,
	output logic [PC_W-1:0] pc_pin_o,
	output logic [PC_W-1:0] pc_pin_oe_n_o,
	output logic [PC_W-1:0] pc_pull_o
);

	// ==========================================================================
	// Elaboration checks
	// ==========================================================================
	if (PA_W != gpw_pkg::PA_WIDTH) begin : g_bad_pa
		$error("Port A width must match the wake-up interface width.");
	end
	if (PB_W < 1 || PB_W > gpw_pkg::REG_W) begin : g_bad_pb
		$error("Port B width must be 1 to 8.");
	end
	if (PC_W < 1 || PC_W > gpw_pkg::REG_W) begin : g_bad_pc
		$error("Port C width must be 1 to 8.");
	end

	// ==========================================================================
	// Per-port state, index 0 is port A, 1 is B, 2 is C
	// ==========================================================================
	localparam int P_CNT = gpw_pkg::PORT_CNT;

	logic [gpw_pkg::REG_W-1:0] port_data [P_CNT];
	logic [gpw_pkg::REG_W-1:0] port_dir [P_CNT];
	logic [gpw_pkg::REG_W-1:0] port_pu [P_CNT];
	logic [gpw_pkg::REG_W-1:0] port_pin [P_CNT];
	logic [gpw_pkg::REG_W-1:0] port_mask [P_CNT];
	logic [gpw_pkg::REG_W-1:0] port_read [P_CNT];
	logic [gpw_pkg::REG_W-1:0] port_a_wake_enable;
	logic [gpw_pkg::ADDR_W-1:0] addr_data [P_CNT];
	logic [gpw_pkg::ADDR_W-1:0] addr_dir [P_CNT];
	logic [gpw_pkg::ADDR_W-1:0] addr_pu [P_CNT];
	gpw_pkg::gpw_mode_t mode;
	gpw_pkg::gpw_mode_t next_mode;
	logic [gpw_pkg::REG_W-1:0] next_rdata;
	logic next_hit;
	logic pa_wake;

	// Unimplemented bits are masked at write time so they always read zero.
	assign port_mask[0] = gpw_pkg::REG_W'((1 << PA_W) - 1);
	assign port_mask[1] = gpw_pkg::REG_W'((1 << PB_W) - 1);
	assign port_mask[2] = gpw_pkg::REG_W'((1 << PC_W) - 1);

	assign port_pin[0] = gpw_pkg::REG_W'(pa_pin_i);
	assign port_pin[1] = gpw_pkg::REG_W'(pb_pin_i);
	assign port_pin[2] = gpw_pkg::REG_W'(pc_pin_i);

	assign addr_data[0] = gpw_pkg::ADDR_PA_DATA;
	assign addr_data[1] = gpw_pkg::ADDR_PB_DATA;
	assign addr_data[2] = gpw_pkg::ADDR_PC_DATA;
	assign addr_dir[0] = gpw_pkg::ADDR_PA_DIR;
	assign addr_dir[1] = gpw_pkg::ADDR_PB_DIR;
	assign addr_dir[2] = gpw_pkg::ADDR_PC_DIR;
	assign addr_pu[0] = gpw_pkg::ADDR_PA_PU;
	assign addr_pu[1] = gpw_pkg::ADDR_PB_PU;
	assign addr_pu[2] = gpw_pkg::ADDR_PC_PU;

	// ==========================================================================
	// Register writes
	// ==========================================================================
	for (genvar p = 0; p < P_CNT; p++) begin : g_port
		// The output latch changes only on a write to its own location.
		always_ff @(posedge core_clk_i) begin
			if (!resetn_i) begin
				port_data[p] <= gpw_pkg::DATA_RST & port_mask[p];
			end else if (mem_wr_i && mem_addr_i == addr_data[p]) begin
				port_data[p] <= mem_wdata_i & port_mask[p];
			end
		end

		always_ff @(posedge core_clk_i) begin
			if (!resetn_i) begin
				port_dir[p] <= gpw_pkg::DIR_RST & port_mask[p];
			end else if (mem_wr_i && mem_addr_i == addr_dir[p]) begin
				port_dir[p] <= mem_wdata_i & port_mask[p];
			end
		end

		always_ff @(posedge core_clk_i) begin
			if (!resetn_i) begin
				port_pu[p] <= gpw_pkg::PU_RST;
			end else if (mem_wr_i && mem_addr_i == addr_pu[p]) begin
				port_pu[p] <= mem_wdata_i & port_mask[p];
			end
		end

		// Input bits show the live pin, output bits show the latch.
		assign port_read[p] = ((port_dir[p] & port_pin[p]) | (~port_dir[p] & port_data[p]))
			& port_mask[p];
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			port_a_wake_enable <= gpw_pkg::WAKE_RST;
		end else if (mem_wr_i && mem_addr_i == gpw_pkg::ADDR_PA_WAKE) begin
			port_a_wake_enable <= mem_wdata_i & port_mask[0];
		end
	end

	// ==========================================================================
	// Register reads
	// ==========================================================================
	// The pin is sampled in the read cycle itself, matching a non-latched input.
	always_comb begin
		next_rdata = gpw_pkg::ZERO;
		next_hit = 1'b1;
		case (mem_addr_i)
			gpw_pkg::ADDR_PA_DATA: next_rdata = port_read[0];
			gpw_pkg::ADDR_PA_DIR: next_rdata = port_dir[0];
			gpw_pkg::ADDR_PA_PU: next_rdata = port_pu[0];
			gpw_pkg::ADDR_PA_WAKE: next_rdata = port_a_wake_enable;
			gpw_pkg::ADDR_PB_DATA: next_rdata = port_read[1];
			gpw_pkg::ADDR_PB_DIR: next_rdata = port_dir[1];
			gpw_pkg::ADDR_PB_PU: next_rdata = port_pu[1];
			gpw_pkg::ADDR_PC_DATA: next_rdata = port_read[2];
			gpw_pkg::ADDR_PC_DIR: next_rdata = port_dir[2];
			gpw_pkg::ADDR_PC_PU: next_rdata = port_pu[2];
			default: next_hit = 1'b0;
		endcase
	end

	// Read data holds until the next read so a slow core can pick it up late.
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			mem_rdata_o <= gpw_pkg::ZERO;
			mem_hit_o <= 1'b0;
		end else if (mem_rd_i) begin
			mem_rdata_o <= next_rdata;
			mem_hit_o <= next_hit;
		end
	end

	// ==========================================================================
	// Pin drivers
	// ==========================================================================
	// Enable is low while driving; pull-high is only offered to input pins.
	always_comb begin
		pa_pin_o = port_data[0][PA_W-1:0];
		pa_pin_oe_n_o = port_dir[0][PA_W-1:0];
		pa_pull_o = port_pu[0][PA_W-1:0] & port_dir[0][PA_W-1:0];
		pb_pin_o = port_data[1][PB_W-1:0];
		pb_pin_oe_n_o = port_dir[1][PB_W-1:0];
		pb_pull_o = port_pu[1][PB_W-1:0] & port_dir[1][PB_W-1:0];
		pc_pin_o = port_data[2][PC_W-1:0];
		pc_pin_oe_n_o = port_dir[2][PC_W-1:0];
		pc_pull_o = port_pu[2][PC_W-1:0] & port_dir[2][PC_W-1:0];
	end

	// ==========================================================================
	// Power mode and wake-up
	// ==========================================================================
	gpw_wake_if wk_if ();

	assign wk_if.pin = pa_pin_i;
	assign wk_if.dir = port_dir[0][PA_W-1:0];
	assign wk_if.wake_en = port_a_wake_enable[PA_W-1:0];
	assign wk_if.low_power = (mode != gpw_pkg::GPW_RUN);
	assign pa_wake = wk_if.wake_req;

	gpw_wake u_wake (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.wk(wk_if.wake)
	);

	// An other_wake_i request in the same cycle as a halt leaves the core running, so that wake is not lost.
	always_comb begin
		next_mode = mode;
		case (mode)
			gpw_pkg::GPW_RUN: begin
				if (halt_i && !other_wake_i) begin
					next_mode = halt_sleep_i ? gpw_pkg::GPW_SLEEP : gpw_pkg::GPW_IDLE;
				end
			end
			gpw_pkg::GPW_IDLE, gpw_pkg::GPW_SLEEP: begin
				if (pa_wake || other_wake_i) begin
					next_mode = gpw_pkg::GPW_RUN;
				end
			end
			default: next_mode = gpw_pkg::GPW_RUN;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			mode <= gpw_pkg::GPW_RUN;
		end else begin
			mode <= next_mode;
		end
	end

	assign power_mode_o = mode;
	assign wake_req_o = pa_wake;

endmodule
`default_nettype wire

/* File: gpw_pin_model.sv */
// Model of the external switches and loads on the pins of one port.
`timescale 1ns/1ps
`default_nettype none
module gpw_pin_model #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic [W-1:0] pin_o_i,
	input wire logic [W-1:0] oe_n_i,
	input wire logic [W-1:0] pull_i,
	input wire logic [W-1:0] ext_en_i,
	input wire logic [W-1:0] ext_val_i,
	output logic [W-1:0] level_o
);
	// An undriven pin without pull-high toggles so a floating read never looks settled.
	logic [W-1:0] flt = '0;
	always @(posedge clk_i) flt <= ~flt;
	// The device driver wins, a switch beats the weak pull-high.
	assign level_o = (~oe_n_i & pin_o_i) | (oe_n_i & ext_en_i & ext_val_i)
		| (oe_n_i & ~ext_en_i & (pull_i | flt));
endmodule
`default_nettype wire

/* File: gpw_checker.sv */
// Checker of bus, pin and power-mode relations at the GPIO top ports.
`timescale 1ns/1ps
`default_nettype none
module gpw_checker #(
	parameter int PA_W = 8,
	parameter int PB_W = 8,
	parameter int PC_W = 6
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic [gpw_pkg::ADDR_W-1:0] mem_addr_i,
	input wire logic mem_wr_i,
	input wire logic mem_rd_i,
	input wire logic [gpw_pkg::REG_W-1:0] mem_wdata_i,
	input wire logic [gpw_pkg::REG_W-1:0] mem_rdata_o,
	input wire logic mem_hit_o,
	input wire logic halt_i,
	input wire logic halt_sleep_i,
	input wire logic other_wake_i,
	input wire logic [1:0] power_mode_o,
	input wire logic wake_req_o,
	input wire logic [PA_W-1:0] pa_pin_o,
	input wire logic [PA_W-1:0] pa_pin_oe_n_o,
	input wire logic [PA_W-1:0] pa_pull_o,
	input wire logic [PB_W-1:0] pb_pin_i,
	input wire logic [PB_W-1:0] pb_pin_o,
	input wire logic [PB_W-1:0] pb_pin_oe_n_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);
	sequence s_halt_ok;
		power_mode_o == 2'h0 && halt_i && !other_wake_i;
	endsequence
	sequence s_woken;
		wake_req_o ##1 power_mode_o == 2'h0;
	endsequence
	a_halt_enter:
		assert property (s_halt_ok |=> power_mode_o == {$past(halt_sleep_i), !$past(halt_sleep_i)})
		else $error("wrong low-power mode after halt");
	a_wake_run:
		assert property (wake_req_o |-> s_woken) else $error("wake did not return to run");
	a_run_quiet:
		assert property ((power_mode_o == 2'h0) [*6] |-> !wake_req_o)
		else $error("wake request while running");
	a_dir_write:
		assert property (mem_wr_i && mem_addr_i == gpw_pkg::ADDR_PA_DIR
			|=> pa_pin_oe_n_o == $past(mem_wdata_i)) else $error("direction write lost");
	a_latch_hold:
		assert property (!(mem_wr_i && mem_addr_i == gpw_pkg::ADDR_PA_DATA) |=> $stable(pa_pin_o))
		else $error("output latch changed without a write");
	a_pull_input:
		assert property ((pa_pull_o & ~pa_pin_oe_n_o) == '0) else $error("pull-high on an output");
	a_pull_write:
		assert property (mem_wr_i && mem_addr_i == gpw_pkg::ADDR_PA_PU
			|=> pa_pull_o == ($past(mem_wdata_i) & pa_pin_oe_n_o))
		else $error("pull-high write not applied");
	a_unmapped_read:
		assert property (mem_rd_i && mem_addr_i == 8'h07 |=> !mem_hit_o && mem_rdata_o == 8'h00)
		else $error("unmapped read answered");
	a_read_pins:
		assert property (mem_rd_i && mem_addr_i == gpw_pkg::ADDR_PB_DATA |=> mem_rdata_o ==
			(($past(pb_pin_o) & ~$past(pb_pin_oe_n_o)) | ($past(pb_pin_i) & $past(pb_pin_oe_n_o))))
		else $error("port read mixes latch and pins wrongly");
endmodule
bind gpw_top gpw_checker #(.PA_W(PA_W), .PB_W(PB_W), .PC_W(PC_W)) i_gpw_checker (.core_clk_i,
	.resetn_i, .mem_addr_i, .mem_wr_i, .mem_rd_i, .mem_wdata_i, .mem_rdata_o, .mem_hit_o,
	.halt_i, .halt_sleep_i, .other_wake_i, .power_mode_o, .wake_req_o, .pa_pin_o,
	.pa_pin_oe_n_o, .pa_pull_o, .pb_pin_i, .pb_pin_o, .pb_pin_oe_n_o);
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the three-port GPIO with port A wake-up.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end
module tb;
	logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, halt = 1'b0, slp = 1'b0, owk = 1'b0;
	logic hit, wreq;
	logic [1:0] mode;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, ra;
	logic [7:0] pa_i, pa_o, pa_oe, pa_pu, pb_i, pb_o, pb_oe, pb_pu;
	logic [5:0] pc_i, pc_o, pc_oe, pc_pu, ec_v = 6'h3f;
	logic [7:0] ea_v = 8'hff, eb_v = 8'hff, eb_en = 8'hff;
	logic [7:0] m [0:15];
	logic [31:0] seed = 32'd64999;
	int error_cnt = 0, n_tests = 0, n;
	always #25 clk = ~clk;
	gpw_top i_gpw_top (.core_clk_i(clk), .resetn_i(rstn), .mem_addr_i(addr), .mem_wr_i(wr),
		.mem_rd_i(rd), .mem_wdata_i(wdata), .mem_rdata_o(rdata), .mem_hit_o(hit), .halt_i(halt),
		.halt_sleep_i(slp), .other_wake_i(owk), .power_mode_o(mode), .wake_req_o(wreq),
		.pa_pin_i(pa_i), .pa_pin_o(pa_o), .pa_pin_oe_n_o(pa_oe), .pa_pull_o(pa_pu),
		.pb_pin_i(pb_i), .pb_pin_o(pb_o), .pb_pin_oe_n_o(pb_oe), .pb_pull_o(pb_pu),
		.pc_pin_i(pc_i), .pc_pin_o(pc_o), .pc_pin_oe_n_o(pc_oe), .pc_pull_o(pc_pu));
	gpw_pin_model #(.W(8)) i_pins_a (.clk_i(clk), .pin_o_i(pa_o), .oe_n_i(pa_oe),
		.pull_i(pa_pu), .ext_en_i(8'hff), .ext_val_i(ea_v), .level_o(pa_i));
	gpw_pin_model #(.W(8)) i_pins_b (.clk_i(clk), .pin_o_i(pb_o), .oe_n_i(pb_oe),
		.pull_i(pb_pu), .ext_en_i(eb_en), .ext_val_i(eb_v), .level_o(pb_i));
	gpw_pin_model #(.W(6)) i_pins_c (.clk_i(clk), .pin_o_i(pc_o), .oe_n_i(pc_oe),
		.pull_i(pc_pu), .ext_en_i(6'h3f), .ext_val_i(ec_v), .level_o(pc_i));
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// Input bits read the pin, output bits read the latch; port B pins without a switch pull high.
	function automatic logic [7:0] exp_rd(input logic [3:0] a);
		logic [7:0] pin;
		pin = (a == 4'h0) ? ea_v : (a == 4'h4) ? ((eb_v & eb_en) | ~eb_en) : {2'h0, ec_v};
		if (a == 4'h7 || a > 4'ha) return 8'h00;
		if (a == 4'h0 || a == 4'h4 || a == 4'h8) return (m[a] & ~m[a+1]) | (pin & m[a+1]);
		return m[a];
	endfunction
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		if (a != 8'h07 && a <= 8'h0a) m[a[3:0]] = (a >= 8'h08) ? (d & 8'h3f) : d;
	endtask
	task automatic rd_chk(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata, exp_rd(a[3:0]))
		`CHK(hit, (a != 8'h07 && a <= 8'h0a))
	endtask
	task automatic halt_go(input logic s);
		@(posedge clk);
		halt <= 1'b1;
		slp <= s;
		@(posedge clk);
		halt <= 1'b0;
		#1;
	endtask
	task automatic give_verdict();
		$display("errors %0d comparisons %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		for (int a = 0; a < 16; a++) m[a] = (a < 2 || a == 4 || a == 5) ? 8'hff : 8'h00;
		m[8] = 8'h3f;
		m[9] = 8'h3f;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		for (int a = 0; a < 12; a++) rd_chk(8'(a));
		for (int k = 0; k < 150; k++) begin
			@(posedge clk);
			ea_v <= xs();
			eb_v <= xs();
			ec_v <= 6'(xs());
			ra = xs() % 8'd12;
			wr_reg(ra, xs());
			#1;
			`CHK({pa_o, pa_oe, pb_o, pb_oe, pc_o, pc_oe}, {m[0], m[1], m[4], m[5], m[8][5:0], m[9][5:0]})
			`CHK({pa_pu, pb_pu, pc_pu}, {m[2] & m[1], m[6] & m[5], m[10][5:0] & m[9][5:0]})
			ra = xs() % 8'd12;
			rd_chk(ra);
		end
		wr_reg(gpw_pkg::ADDR_PB_DIR, 8'hff);
		wr_reg(gpw_pkg::ADDR_PB_PU, 8'hff);
		@(posedge clk);
		eb_en <= 8'h00;
		rd_chk(gpw_pkg::ADDR_PB_DATA);
		@(posedge clk);
		eb_en <= 8'hff;
		ea_v <= 8'hff;
		wr_reg(gpw_pkg::ADDR_PA_DIR, 8'hff);
		for (int i = 0; i < 8; i++) begin
			wr_reg(gpw_pkg::ADDR_PA_WAKE, 8'h01 << i);
			halt_go(i[0]);
			`CHK(mode, i[0] ? 2'h2 : 2'h1)
			@(posedge clk);
			ea_v <= ~(8'h01 << ((i + 1) % 8));
			repeat (6) @(posedge clk);
			#1;
			`CHK(mode, i[0] ? 2'h2 : 2'h1)
			@(posedge clk);
			ea_v <= ea_v & ~(8'h01 << i);
			for (n = 1; n <= 10; n++) begin
				@(posedge clk);
				#1;
				if (wreq === 1'b1) break;
			end
			`CHK(n, 3)
			if (n > 10) give_verdict();
			@(posedge clk);
			#1;
			`CHK(mode, 2'h0)
			@(posedge clk);
			ea_v <= 8'hff;
		end
		// Falling levels on output pins must not wake, even with every enable set.
		wr_reg(gpw_pkg::ADDR_PA_DATA, 8'hff);
		wr_reg(gpw_pkg::ADDR_PA_DIR, 8'h00);
		wr_reg(gpw_pkg::ADDR_PA_WAKE, 8'hff);
		halt_go(1'b0);
		wr_reg(gpw_pkg::ADDR_PA_DATA, 8'h00);
		repeat (6) @(posedge clk);
		#1;
		`CHK({mode, wreq}, 3'h2)
		@(posedge clk);
		owk <= 1'b1;
		halt_go(1'b1);
		`CHK(mode, 2'h0)
		owk <= 1'b0;
		give_verdict();
	end
endmodule
`default_nettype wire
